// [periph_irq_pkg.sv]
// constants for the peripheral interrupt pending block
//
// Summary of operation
// - a source event sets its pending bit, and the matching summary bit only when its slot's mask bit is set.
// - taking a summary vector clears only that summary bit, never the pending bits.
// - a pending register read returns its contents, then clears each slot bit unless its own event lands that cycle; reserved bits keep reset values.
// - writing a one to a pending bit raises the interrupt like a real source event.
// - with a waveform generator, pending bit 4 shows it and feeds the peripheral summary.
// - the peripheral summary reaches the core only while main enable bit 5 is set.
// - a waveform event feeds the peripheral summary only while enable bit 5 is set.
// - with two serial ports, a pending bit shows serial 1 errors for the serial summary.
// - with compare channel 5, pending bit 6 shows it and feeds the peripheral summary.
package periph_irq_pkg;

    // register addresses, byte granular
    localparam logic [15:0] PEND_ADDR = 16'h1fbe;
    localparam logic [15:0] PMASK_ADDR = 16'h1fbf;
    localparam logic [15:0] IPH_ADDR = 16'h0012;
    localparam logic [15:0] IEH_ADDR = 16'h0013;

    // reset values
    localparam logic [7:0] PEND_RESET = 8'haa;
    localparam logic [7:0] PMASK_RESET = 8'h00;
    localparam logic [7:0] IEH_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // reserved pending bits read back as their reset ones
    localparam logic [7:0] PEND_RSVD = 8'haa;

    // source slots: slot 0 at pending bit 4, slot 1 at bit 6
    localparam int SLOTS = 2;
    localparam int SLOT_BASE = 4;
    localparam int SLOT_STEP = 2;
    // slot 0 enabled by mask bit 5, slot 1 by bit 6
    localparam int MASK_BASE = 5;

    // summary bits in the main pending and enable registers
    localparam int SUM_PERIPH = 5;
    localparam int SUM_SERIAL = 6;

endpackage : periph_irq_pkg

// [sticky_flag.sv]
// one sticky flag bit where a set beats a clear
`timescale 1ns/1ps
module sticky_flag #(
    parameter bit RESET_VAL = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic q_o
);

    logic flag_d;

    // a set arriving with a clear is kept, so no event is lost
    assign flag_d = set_i | (q_o & ~clr_i);

    // flag storage
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_o <= RESET_VAL;
        end else begin
            q_o <= flag_d;
        end
    end

endmodule : sticky_flag

// [periph_irq_pending.sv]
// peripheral interrupt pending register with summary interrupts
`timescale 1ns/1ps
module periph_irq_pending #(
    // 0: waveform generator and compare channel 5; 1: two serial ports
    parameter bit TWO_SERIAL = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic waveform_gen_source_i,
    input wire logic compare_ch5_source_i,
    input wire logic serial0_error_source_i,
    input wire logic serial1_error_source_i,
    input wire logic periph_vec_taken_i,
    input wire logic serial_vec_taken_i,
    output logic periph_summary_irq_o,
    output logic serial_summary_irq_o,
    output logic irq_o
);

    // address decode
    logic sel_pend;
    logic sel_pmask;
    logic sel_iph;
    logic sel_ieh;

    assign sel_pend = (addr_i == periph_irq_pkg::PEND_ADDR);
    assign sel_pmask = (addr_i == periph_irq_pkg::PMASK_ADDR);
    assign sel_iph = (addr_i == periph_irq_pkg::IPH_ADDR);
    assign sel_ieh = (addr_i == periph_irq_pkg::IEH_ADDR);

    // qualified strobes
    logic wr_pend;
    logic rd_pend;
    logic wr_pmask;
    logic wr_iph;
    logic wr_ieh;

    assign wr_pend = wr_i & sel_pend;
    assign rd_pend = rd_i & sel_pend;
    assign wr_pmask = wr_i & sel_pmask;
    assign wr_iph = wr_i & sel_iph;
    assign wr_ieh = wr_i & sel_ieh;

    // software registers
    logic [7:0] periph_enable_reg_q;
    logic [7:0] irq_enable_high_q;
    logic [7:0] irq_pending_high;

    // enable registers: plain read/write
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            periph_enable_reg_q <= periph_irq_pkg::PMASK_RESET;
        end else if (wr_pmask) begin
            periph_enable_reg_q <= wdata_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_enable_high_q <= periph_irq_pkg::IEH_RESET;
        end else if (wr_ieh) begin
            irq_enable_high_q <= wdata_i;
        end
    end

    // per-slot source selection, set by the variant
    logic [1:0] slot_src;

    assign slot_src[0] = TWO_SERIAL ? serial0_error_source_i
                                    : waveform_gen_source_i;
    assign slot_src[1] = TWO_SERIAL ? serial1_error_source_i
                                    : compare_ch5_source_i;

    // pending bits, event terms and summary contributions per slot
    logic [1:0] slot_ev;
    logic [1:0] slot_pend;
    logic [1:0] slot_contrib;

    genvar gi;
    generate
        for (gi = 0; gi < periph_irq_pkg::SLOTS; gi++) begin : g_slot
            localparam int POS = periph_irq_pkg::SLOT_BASE + gi * periph_irq_pkg::SLOT_STEP;
            localparam int MPOS = periph_irq_pkg::MASK_BASE + gi;

            // a written one counts exactly like a source event
            assign slot_ev[gi] = slot_src[gi] | (wr_pend & wdata_i[POS]);

            // only an enabled slot feeds its summary
            assign slot_contrib[gi] = slot_ev[gi] & periph_enable_reg_q[MPOS];

            // read clears, but a new event in the read cycle survives
            sticky_flag #(
                .RESET_VAL(periph_irq_pkg::PEND_RESET[POS])
            ) u_pend (
                .core_clk_i(core_clk_i),
                .rst_n_i(rst_n_i),
                .set_i(slot_ev[gi]),
                .clr_i(rd_pend),
                .q_o(slot_pend[gi])
            );
        end
    endgenerate

    // summary set terms: the variant decides which summary the slots feed
    logic periph_set;
    logic serial_set;

    assign periph_set = ~TWO_SERIAL & (|slot_contrib);
    assign serial_set = TWO_SERIAL & (|slot_contrib);

    // summary clears: vector taken or software write of one
    logic periph_clr;
    logic serial_clr;

    assign periph_clr = periph_vec_taken_i | (wr_iph & wdata_i[periph_irq_pkg::SUM_PERIPH]);
    assign serial_clr = serial_vec_taken_i | (wr_iph & wdata_i[periph_irq_pkg::SUM_SERIAL]);

    logic periph_sum_q;
    logic serial_sum_q;

    // vector take touches the summary only, pending bits keep their state
    sticky_flag #(
        .RESET_VAL(1'b0)
    ) u_sum_periph (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .set_i(periph_set),
        .clr_i(periph_clr),
        .q_o(periph_sum_q)
    );

    sticky_flag #(
        .RESET_VAL(1'b0)
    ) u_sum_serial (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .set_i(serial_set),
        .clr_i(serial_clr),
        .q_o(serial_sum_q)
    );

    // main pending image, unused bits read zero
    always_comb begin
        irq_pending_high = periph_irq_pkg::ZERO_BYTE;
        irq_pending_high[periph_irq_pkg::SUM_PERIPH] = periph_sum_q;
        irq_pending_high[periph_irq_pkg::SUM_SERIAL] = serial_sum_q;
    end

    // pending register image: slots plus reserved read-back
    logic [7:0] pend_image;

    always_comb begin
        pend_image = periph_irq_pkg::PEND_RSVD;
        pend_image[periph_irq_pkg::SLOT_BASE] = slot_pend[0];
        pend_image[periph_irq_pkg::SLOT_BASE + periph_irq_pkg::SLOT_STEP] = slot_pend[1];
    end

    // read mux; unmapped addresses read zero
    logic [7:0] rd_mux;

    assign rd_mux = sel_pend ? pend_image :
                    sel_pmask ? periph_enable_reg_q :
                    sel_iph ? irq_pending_high :
                    sel_ieh ? irq_enable_high_q :
                    periph_irq_pkg::ZERO_BYTE;

    // gated summaries toward the core
    logic periph_gate;
    logic serial_gate;
    logic irq_any;

    assign periph_gate = periph_sum_q & irq_enable_high_q[periph_irq_pkg::SUM_PERIPH];
    assign serial_gate = serial_sum_q & irq_enable_high_q[periph_irq_pkg::SUM_SERIAL];
    assign irq_any = periph_gate | serial_gate;

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= periph_irq_pkg::ZERO_BYTE;
        end else begin
            rdata_o <= rd_i ? rd_mux : periph_irq_pkg::ZERO_BYTE;
        end
    end

    // registered interrupt outputs, one cycle after the flag
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            periph_summary_irq_o <= 1'b0;
            serial_summary_irq_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            periph_summary_irq_o <= periph_gate;
            serial_summary_irq_o <= serial_gate;
            irq_o <= irq_any;
        end
    end

    // checks on the pending and summary behaviour
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // a read in an event quiet cycle
    sequence s_read_no_event;
        rd_pend && (slot_ev == 2'b00);
    endsequence

    sequence s_periph_live;
        periph_sum_q && irq_enable_high_q[periph_irq_pkg::SUM_PERIPH];
    endsequence

    a_source_sets_sum: assert property (
        periph_set |=> periph_sum_q ##1 (periph_sum_q || $past(periph_clr))
    ) else $error("summary bit not set by source event");

    a_vec_keeps_pend: assert property (
        (periph_vec_taken_i && !periph_set && !rd_pend && (slot_ev == 2'b00))
            |=> (!periph_sum_q && (slot_pend == $past(slot_pend)))
    ) else $error("vector take disturbed pending bits");

    a_read_clears_all: assert property (
        s_read_no_event |=> (slot_pend == 2'b00)
    ) else $error("read did not clear pending bits");

    a_read_returns_old: assert property (
        rd_pend |=> (rdata_o == $past(pend_image))
    ) else $error("read data not the pre-clear contents");

    a_sw_write_raises: assert property (
        (wr_pend && wdata_i[periph_irq_pkg::SLOT_BASE]
            && periph_enable_reg_q[periph_irq_pkg::MASK_BASE])
            |=> (slot_pend[0] && (periph_sum_q || serial_sum_q))
    ) else $error("software write did not raise interrupt");

    a_wave_slot_bit: assert property (
        (!TWO_SERIAL && waveform_gen_source_i)
            |=> pend_image[periph_irq_pkg::SLOT_BASE]
    ) else $error("waveform event not pending at bit 4");

    a_periph_gated: assert property (
        s_periph_live |=> periph_summary_irq_o
    ) else $error("enabled summary did not reach core");

    a_periph_blocked: assert property (
        !irq_enable_high_q[periph_irq_pkg::SUM_PERIPH] |=> !periph_summary_irq_o
    ) else $error("summary reached core while disabled");

    a_mask_holds_sum: assert property (
        (!periph_sum_q && (slot_contrib == 2'b00)) |=> !periph_sum_q
    ) else $error("masked event set the summary");

    a_serial1_slot: assert property (
        (TWO_SERIAL && serial1_error_source_i && periph_enable_reg_q[periph_irq_pkg::MASK_BASE + 1])
            |=> (slot_pend[1] && serial_sum_q)
    ) else $error("serial 1 error not pending");

    a_compare_slot: assert property (
        (!TWO_SERIAL && compare_ch5_source_i)
            |=> pend_image[periph_irq_pkg::SLOT_BASE + periph_irq_pkg::SLOT_STEP]
    ) else $error("compare channel 5 not pending at bit 6");

    a_serial0_slot: assert property (
        (TWO_SERIAL && serial0_error_source_i && periph_enable_reg_q[periph_irq_pkg::MASK_BASE])
            |=> (slot_pend[0] && serial_sum_q && !periph_sum_q)
    ) else $error("serial 0 error not routed to serial summary");

    // each raised slot is pending next cycle, enabled or not
    a_event_pends: assert property (
        (slot_ev != 2'b00) |=> ((slot_pend & $past(slot_ev)) == $past(slot_ev))
    ) else $error("event did not set its pending bit");

    // pending bits only move on an event or a read
    a_pend_sticky: assert property (
        (!rd_pend && (slot_ev == 2'b00)) |=> (slot_pend == $past(slot_pend))
    ) else $error("pending bit changed without cause");

    // serial slots feed the serial summary instead
    a_serial_sets_sum: assert property (
        serial_set |=> serial_sum_q
    ) else $error("serial summary not set by serial event");

    // serial vector take clears its summary unless a new event lands
    a_serial_vec_clears: assert property (
        (serial_vec_taken_i && !serial_set) |=> !serial_sum_q
    ) else $error("serial vector take left summary set");

    // a summary never drops without a take or a software clear
    a_sum_sticky: assert property (
        (periph_sum_q && !periph_clr) |=> periph_sum_q
    ) else $error("peripheral summary dropped on its own");

    // zeros written to the pending register are no events
    a_write_zero_quiet: assert property (
        (wr_pend && !wdata_i[periph_irq_pkg::SLOT_BASE]
            && !slot_src[0] && !slot_pend[0]) |=> !slot_pend[0]
    ) else $error("written zero raised a pending bit");

    // enable register takes the written byte as is
    a_enable_write: assert property (
        wr_pmask |=> (periph_enable_reg_q == $past(wdata_i))
    ) else $error("enable register write lost");

    // serial summary reaches the core only through its enable bit
    a_serial_gated: assert property (
        (serial_sum_q && irq_enable_high_q[periph_irq_pkg::SUM_SERIAL])
            |=> serial_summary_irq_o
    ) else $error("enabled serial summary did not reach core");

    a_serial_blocked: assert property (
        !irq_enable_high_q[periph_irq_pkg::SUM_SERIAL] |=> !serial_summary_irq_o
    ) else $error("serial summary reached core while disabled");

    // the single core line follows the gated summaries one cycle late
    a_irq_follows: assert property (
        (periph_gate || serial_gate) |=> irq_o
    ) else $error("core interrupt line missed a live summary");

    a_irq_quiet: assert property (
        (!periph_gate && !serial_gate) |=> !irq_o
    ) else $error("core interrupt line high with no live summary");

    // idle zero on read data, so a stale byte is never mistaken for an answer
    a_rdata_idle: assert property (
        !rd_i |=> (rdata_o == periph_irq_pkg::ZERO_BYTE)
    ) else $error("read data not idle");

    // enabled slot event walks to the core pin in two cycles
    sequence s_wave_enabled;
        !TWO_SERIAL && waveform_gen_source_i
            && periph_enable_reg_q[periph_irq_pkg::MASK_BASE]
            && irq_enable_high_q[periph_irq_pkg::SUM_PERIPH] && !wr_ieh;
    endsequence

    sequence s_cmp_enabled;
        !TWO_SERIAL && compare_ch5_source_i
            && periph_enable_reg_q[periph_irq_pkg::MASK_BASE + 1]
            && irq_enable_high_q[periph_irq_pkg::SUM_PERIPH] && !wr_ieh;
    endsequence

    sequence s_sum_then_pin;
        periph_sum_q ##1 periph_summary_irq_o;
    endsequence

    a_wave_reaches_core: assert property (
        s_wave_enabled |=> s_sum_then_pin
    ) else $error("enabled waveform event did not reach core");

    a_cmp_reaches_core: assert property (
        s_cmp_enabled |=> s_sum_then_pin
    ) else $error("enabled compare event did not reach core");

endmodule : periph_irq_pending

// [periph_core_model.sv]
// peripheral event sources and core vector taker facing the pending block
`timescale 1ns/1ps
module periph_core_model (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] fire_i,
    input wire logic take_en_i,
    input wire logic slow_i,
    input wire logic [1:0] irq_i,
    output logic [1:0] src_o,
    output logic [1:0] take_o
);
    logic [1:0] seen_q;
    logic [1:0] hold_q;
    logic [1:0] take_d;
    // slow core waits a cycle; hold_q stops a second take while the level drops
    assign take_d = irq_i & ~take_o & ~hold_q & (slow_i ? seen_q : 2'b11) & {2{take_en_i}};
    // one-cycle event pulses, vector taken on the summary level
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_o <= 2'b00;
            seen_q <= 2'b00;
            hold_q <= 2'b00;
            take_o <= 2'b00;
        end else begin
            src_o <= fire_i;
            seen_q <= irq_i;
            hold_q <= take_o;
            take_o <= take_d;
        end
    end
endmodule : periph_core_model

// [periph_irq_pending_tb.sv]
// self-checking bench for the peripheral interrupt pending block
`timescale 1ns/1ps
module periph_irq_pending_tb;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [1:0] fire = 2'b00;
    logic take_en = 1'b0;
    logic slow = 1'b0;
    logic [1:0] src, take, sum_a, sum_b;
    logic [7:0] rdata_a, rdata_b;
    logic irq_a, irq_b;
    int fail_count = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'h0000_2f9a;
    logic [1:0] p;
    logic [7:0] pm, ie, s0, s1;

    always #4 core_clk_i = ~core_clk_i;

    // uut carries waveform and compare slots, uut_ser the two serial slots
    periph_irq_pending #(.TWO_SERIAL(1'b0)) uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_a),
        .waveform_gen_source_i(src[0]), .compare_ch5_source_i(src[1]),
        .serial0_error_source_i(src[0]), .serial1_error_source_i(src[1]),
        .periph_vec_taken_i(take[0]), .serial_vec_taken_i(take[1]),
        .periph_summary_irq_o(sum_a[0]), .serial_summary_irq_o(sum_a[1]), .irq_o(irq_a));
    periph_irq_pending #(.TWO_SERIAL(1'b1)) uut_ser (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_b), .waveform_gen_source_i(src[0]), .compare_ch5_source_i(src[1]),
        .serial0_error_source_i(src[0]), .serial1_error_source_i(src[1]),
        .periph_vec_taken_i(take[0]), .serial_vec_taken_i(take[1]),
        .periph_summary_irq_o(sum_b[0]), .serial_summary_irq_o(sum_b[1]), .irq_o(irq_b));
    // partner takes the peripheral vector of uut and the serial vector of uut_ser
    periph_core_model partner (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .fire_i(fire),
        .take_en_i(take_en), .slow_i(slow), .irq_i({sum_b[1], sum_a[0]}), .src_o(src),
        .take_o(take));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    // slots sit at pending bits 4 and 6, reserved bits read back PEND_RSVD
    function automatic logic [7:0] pend_exp(input logic [1:0] v);
        return periph_irq_pkg::PEND_RSVD | {1'b0, v[1], 1'b0, v[0], 4'h0};
    endfunction : pend_exp

    // output terms: summary bit and enable bit, then their or
    function automatic logic [7:0] irq_exp(input logic [7:0] s, input logic [7:0] e);
        logic [7:0] t;
        t = s & e & 8'h60;
        return {5'h00, |t, t[6], t[5]};
    endfunction : irq_exp

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic stop_test();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    // shadow update: pending always set, summary only through an enabled slot
    task automatic ev(input logic [1:0] v);
        logic hit;
        hit = |(v & {pm[6], pm[5]});
        p |= v;
        s0[5] |= hit;
        s1[6] |= hit;
    endtask : ev

    task automatic fire_ev(input logic [1:0] v);
        @(posedge core_clk_i) fire <= v;
        @(posedge core_clk_i) fire <= 2'b00;
        @(posedge core_clk_i);
        ev(v);
    endtask : fire_ev

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_i) begin
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
        end
        @(posedge core_clk_i) wr_i <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] ea, input logic [7:0] eb,
                      input string nm);
        @(posedge core_clk_i) begin
            addr_i <= a;
            rd_i <= 1'b1;
        end
        @(posedge core_clk_i) rd_i <= 1'b0;
        @(negedge core_clk_i);
        chk(rdata_a, ea, nm);
        chk(rdata_b, eb, nm);
    endtask : rd

    task automatic irq_chk();
        repeat (2) @(posedge core_clk_i);
        @(negedge core_clk_i);
        chk({5'h00, irq_a, sum_a}, irq_exp(s0, ie), "outputs a");
        chk({5'h00, irq_b, sum_b}, irq_exp(s1, ie), "outputs b");
    endtask : irq_chk

    // watchdog: whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk_i);
        fail_count++;
        stop_test();
    end

    initial begin
        {p, pm, ie, s0, s1} = '0;
        repeat (12) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rd(periph_irq_pkg::PEND_ADDR, 8'haa, 8'haa, "pending reset");
        rd(periph_irq_pkg::PMASK_ADDR, 8'h00, 8'h00, "enable reset");
        rd(16'h1fc0, 8'h00, 8'h00, "unmapped");
        // events with all slots disabled: pending only, no summary
        fire_ev(2'b11);
        rd(periph_irq_pkg::IPH_ADDR, s0, s1, "summary masked");
        rd(periph_irq_pkg::PEND_ADDR, 8'hfa, 8'hfa, "pending both");
        rd(periph_irq_pkg::PEND_ADDR, 8'haa, 8'haa, "pending cleared");
        p = 2'b00;
        repeat (80) begin
            seed = xs(seed);
            case (seed % 7)
                0: fire_ev(seed[9:8]);
                1: begin
                    pm = seed[15:8] & 8'h60;
                    wr(periph_irq_pkg::PMASK_ADDR, pm);
                end
                2: begin
                    ie = seed[15:8] & 8'h60;
                    wr(periph_irq_pkg::IEH_ADDR, ie);
                end
                3: begin
                    rd(periph_irq_pkg::PEND_ADDR, pend_exp(p), pend_exp(p), "pending");
                    p = 2'b00;
                end
                4: begin
                    wr(periph_irq_pkg::PEND_ADDR, seed[15:8]);
                    ev({seed[14], seed[12]});
                end
                5: begin
                    wr(periph_irq_pkg::IPH_ADDR, seed[15:8]);
                    s0 &= ~seed[15:8];
                    s1 &= ~seed[15:8];
                end
                default: rd(periph_irq_pkg::IPH_ADDR, s0, s1, "summary");
            endcase
            irq_chk();
        end
        // core takes the vector, promptly then slowly; pending bits stay
        pm = 8'h60;
        ie = 8'h60;
        wr(periph_irq_pkg::PMASK_ADDR, pm);
        wr(periph_irq_pkg::IEH_ADDR, ie);
        @(posedge core_clk_i) take_en <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk_i) slow <= i[0];
            fire_ev(2'b01);
            repeat (6) @(posedge core_clk_i);
            s0 = 8'h00;
            s1 = 8'h00;
            rd(periph_irq_pkg::IPH_ADDR, s0, s1, "summary after take");
            rd(periph_irq_pkg::PEND_ADDR, pend_exp(p), pend_exp(p), "pending kept");
            p = 2'b00;
            irq_chk();
        end
        stop_test();
    end
endmodule : periph_irq_pending_tb
